// ===== sadc_device.sv
// converter-side end: control register, result register and SAR sequencer
// ----------------------------------------------------------------------
// Summary of operation
// - sequencer steps on oscillator divided by twelve
// - successive approximation gives 8-bit read-only result
// - writing start with power set in the same write begins conversion, clears end flag
// - completion sets end flag; result then valid
// - one conversion per start; no free running
// - start during conversion restarts it at once
// - start bit is write-only, reads zero
// - interrupt vector four when flag and enable
// - control bits: enable, flag, start, power
// - power select zero holds converter idle
// - reset aborts conversion, control becomes 40h
// - end flag is read-only to software
// - result register at d0h, eight bits
// - control register read/write at d1h
// - software powers converter before starting
// - wait state does not unpower the converter
// - software selects one analog line only
// - conversion takes about 70us at 8MHz
// - completion interrupt can wake from wait
// ----------------------------------------------------------------------
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_device
   import sadc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   sadc_bus_if.device      bus,
   input  wire logic       cmp_in,
   output logic [7:0]      dac_code,
   output logic            conv_power,
   output logic            conv_busy
);
   // ----------------------------------------------------------------------
   // local constants
   // ----------------------------------------------------------------------
   localparam logic [3:0] DIV_LAST = 4'(`SADC_DIV - 1);
   localparam logic [5:0] ACQ_LAST = 6'(`SADC_ACQ_STEPS - 1);
   localparam logic [5:0] BIT_LAST = 6'(`SADC_BIT_STEPS - 1);
   localparam logic [7:0] CTRL_RST = `SADC_CTRL_RESET;

   // ----------------------------------------------------------------------
   // one trial step of the approximation: settle bit, raise the next
   // ----------------------------------------------------------------------
   function automatic sadc_byte_t sar_step(input sadc_byte_t cur,
                                           input logic [2:0] idx,
                                           input logic       keep);
      sadc_byte_t r;
      logic [2:0] pos;
      r      = cur;
      pos    = 3'h7 - idx;
      r[pos] = keep;
      if (pos != 3'h0)
         r[pos - 3'h1] = 1'b1;
      return r;
   endfunction : sar_step

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic        ien_q;
   logic        eoc_q;
   logic        pwr_q;
   sadc_byte_t  result_q;
   sadc_byte_t  sar_q;
   sadc_state_t state_q;
   logic [5:0]  step_q;
   logic [3:0]  div_q;
   logic        tick_q;
   logic        cmp_s1_q, cmp_s2_q;
   logic        wr_ctrl;
   logic        start_w;
   logic        done_w;

   // ----------------------------------------------------------------------
   // comparator input synchroniser
   // ----------------------------------------------------------------------
   // first stage is read by the second stage only
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         cmp_s1_q <= cmp_in;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // ----------------------------------------------------------------------
   // step clock enable
   // ----------------------------------------------------------------------
   // divide by twelve into a one-cycle step pulse
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         div_q  <= 4'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == DIV_LAST);
         div_q  <= (div_q == DIV_LAST) ? 4'h0 : div_q + 4'h1;
      end
   end

   // ----------------------------------------------------------------------
   // register access decode
   // ----------------------------------------------------------------------
   // a start only counts when the same write leaves the converter powered
   assign wr_ctrl = bus.cpu_wr && (bus.cpu_addr == `SADC_CTRL_ADDR);
   assign start_w = wr_ctrl && bus.cpu_wdata[`SADC_STA_BIT]
                    && bus.cpu_wdata[`SADC_PWR_BIT];
   assign done_w  = tick_q && (state_q == SADC_BITS) && (step_q == BIT_LAST)
                    && !start_w && pwr_q;

   // ----------------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------------
   // enable and power are plain bits; the end flag ignores writes
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ien_q <= CTRL_RST[`SADC_IEN_BIT];
         pwr_q <= CTRL_RST[`SADC_PWR_BIT];
      end else if (wr_ctrl) begin
         ien_q <= bus.cpu_wdata[`SADC_IEN_BIT];
         pwr_q <= bus.cpu_wdata[`SADC_PWR_BIT];
      end
   end

   // end-of-conversion flag: a start clear wins over a completion set, which is suppressed by the start
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         eoc_q <= CTRL_RST[`SADC_EOC_BIT];
      else if (done_w)
         eoc_q <= 1'b1;
      else if (start_w)
         eoc_q <= 1'b0;
   end

   // ----------------------------------------------------------------------
   // sequencer: acquisition steps then eight bit steps
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= SADC_IDLE;
         step_q  <= 6'h0;
         sar_q   <= 8'h00;
      end else if (start_w) begin
         state_q <= SADC_ACQ;
         step_q  <= 6'h0;
         sar_q   <= 8'h80;
      end else if (!pwr_q) begin
         state_q <= SADC_IDLE;
         step_q  <= 6'h0;
      end else if (tick_q) begin
         case (state_q)
            SADC_ACQ: begin
               if (step_q == ACQ_LAST) begin
                  state_q <= SADC_BITS;
                  step_q  <= 6'h0;
               end else begin
                  step_q <= step_q + 6'h1;
               end
            end
            SADC_BITS: begin
               sar_q <= sar_step(sar_q, step_q[2:0], cmp_s2_q);
               if (step_q == BIT_LAST) begin
                  state_q <= SADC_IDLE;
                  step_q  <= 6'h0;
               end else begin
                  step_q <= step_q + 6'h1;
               end
            end
            SADC_IDLE: begin
               step_q <= 6'h0;
            end
            default: begin
               state_q <= SADC_IDLE;
               step_q  <= 6'h0;
            end
         endcase
      end
   end

   // result captured together with the end flag
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         result_q <= 8'h00;
      else if (done_w)
         result_q <= sar_step(sar_q, step_q[2:0], cmp_s2_q);
   end

   // ----------------------------------------------------------------------
   // read answers and interrupt request
   // ----------------------------------------------------------------------
   // reads answer one cycle after the strobe; unused bits read zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         bus.dev_rdata  <= 8'h00;
         bus.dev_rvalid <= 1'b0;
      end else begin
         bus.dev_rvalid <= bus.cpu_rd;
         if (bus.cpu_rd) begin
            case (bus.cpu_addr)
               `SADC_RESULT_ADDR: bus.dev_rdata <= result_q;
               `SADC_CTRL_ADDR:   bus.dev_rdata <= {ien_q, eoc_q, 1'b0, pwr_q, 4'h0};
               default:           bus.dev_rdata <= 8'h00;
            endcase
         end
      end
   end

   // interrupt on the vector-four line, independent of wait state
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         bus.dev_irq <= 1'b0;
      else
         bus.dev_irq <= eoc_q && ien_q;
   end

   // ----------------------------------------------------------------------
   // analog-side outputs
   // ----------------------------------------------------------------------
   // power follows the select bit only, never the wait state
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         dac_code   <= 8'h00;
         conv_power <= 1'b0;
         conv_busy  <= 1'b0;
      end else begin
         dac_code   <= sar_q;
         conv_power <= pwr_q;
         conv_busy  <= (state_q != SADC_IDLE);
      end
   end

endmodule : sadc_device

// ===== sadc_cfg.svh
// constants of the converter control block: offsets, fields, reset values, timing
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// ----------------------------------------------------------------------
// data-space register offsets (processor side)
// ----------------------------------------------------------------------
`define SADC_RESULT_ADDR   8'hd0
`define SADC_CTRL_ADDR     8'hd1

// ----------------------------------------------------------------------
// converter_control fields
// ----------------------------------------------------------------------
`define SADC_IEN_BIT       7
`define SADC_EOC_BIT       6
`define SADC_STA_BIT       5
`define SADC_PWR_BIT       4
`define SADC_CTRL_RESET    8'h40
`define SADC_IRQ_VECTOR    3'h4

// ----------------------------------------------------------------------
// timing: sequencer steps from the oscillator divided by twelve
// ----------------------------------------------------------------------
`define SADC_DIV           12
`define SADC_OSC_KHZ       8000
`define SADC_CONV_NS       70000
`define SADC_CONV_STEPS    ((`SADC_CONV_NS * `SADC_OSC_KHZ) / (`SADC_DIV * 1000000))
`define SADC_BIT_STEPS     8
`define SADC_ACQ_STEPS     (`SADC_CONV_STEPS - `SADC_BIT_STEPS)

// ----------------------------------------------------------------------
// host registers on the AXI4-Lite side (byte addresses)
// ----------------------------------------------------------------------
`define SADC_H_CMD_ADDR    4'h0
`define SADC_H_STAT_ADDR   4'h4
`define SADC_H_CTRL_ADDR   4'h8
`define SADC_H_CMD_WR_BIT  16
`define SADC_RESP_OKAY     2'b00
`define SADC_RESP_SLVERR   2'b10

`endif

// ===== sadc_pkg.sv
// types shared by both ends of the converter control block
package sadc_pkg;

   // ----------------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SADC_IDLE = 2'b00,
      SADC_ACQ  = 2'b01,
      SADC_BITS = 2'b10
   } sadc_state_t;

   typedef logic [7:0] sadc_byte_t;

endpackage : sadc_pkg

// ===== sadc_bus_if.sv
// data-space register bus between processor side and converter control
`timescale 1ns/1ps
interface sadc_bus_if;
   logic [7:0] cpu_addr;
   logic       cpu_wr;
   logic       cpu_rd;
   logic [7:0] cpu_wdata;
   logic [7:0] dev_rdata;
   logic       dev_rvalid;
   logic       dev_irq;

   modport device (
      input  cpu_addr,
      input  cpu_wr,
      input  cpu_rd,
      input  cpu_wdata,
      output dev_rdata,
      output dev_rvalid,
      output dev_irq
   );

   modport host (
      output cpu_addr,
      output cpu_wr,
      output cpu_rd,
      output cpu_wdata,
      input  dev_rdata,
      input  dev_rvalid,
      input  dev_irq
   );
endinterface : sadc_bus_if

// ===== sadc_host.sv
// processor-side end: AXI4-Lite slave that drives the data-space bus
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_host
   import sadc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   sadc_bus_if.host         bus,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq_vec4,
   output logic             wait_mode
);
   // ----------------------------------------------------------------------
   // write channel holding
   // ----------------------------------------------------------------------
   logic       aw_have_q, w_have_q, aw_have_d, w_have_d;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic       exec, b_fire, r_fire, bvalid_d;
   sadc_byte_t rd_data_q;
   logic       rd_pend_q;

   assign exec   = aw_have_q && w_have_q && !s_axi_bvalid;
   assign b_fire = s_axi_bvalid && s_axi_bready;
   assign r_fire = s_axi_rvalid && s_axi_rready;

   // next holding state for address and data
   always_comb begin
      aw_have_d = (aw_have_q && !exec) || (s_axi_awvalid && s_axi_awready);
      w_have_d  = (w_have_q && !exec) || (s_axi_wvalid && s_axi_wready);
      bvalid_d  = exec || (s_axi_bvalid && !b_fire);
   end

   // address and data taken in either order, one write at a time
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SADC_RESP_OKAY;
         aw_addr_q     <= 4'h0;
         w_data_q      <= 32'h0;
         w_strb_q      <= 4'h0;
      end else begin
         aw_have_q     <= aw_have_d;
         w_have_q      <= w_have_d;
         s_axi_awready <= !aw_have_d && !bvalid_d;
         s_axi_wready  <= !w_have_d && !bvalid_d;
         s_axi_bvalid  <= bvalid_d;
         if (s_axi_awvalid && s_axi_awready) aw_addr_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (exec)
            s_axi_bresp <= (aw_addr_q == `SADC_H_CMD_ADDR || aw_addr_q == `SADC_H_CTRL_ADDR)
                           ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------------
   // data-space access issue and answer capture
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         bus.cpu_addr  <= 8'h0;
         bus.cpu_wdata <= 8'h0;
         bus.cpu_wr    <= 1'b0;
         bus.cpu_rd    <= 1'b0;
         rd_pend_q     <= 1'b0;
         rd_data_q     <= 8'h0;
         wait_mode     <= 1'b0;
         irq_vec4      <= 1'b0;
      end else begin
         bus.cpu_wr <= 1'b0;
         bus.cpu_rd <= 1'b0;
         irq_vec4   <= bus.dev_irq;
         if (exec && aw_addr_q == `SADC_H_CMD_ADDR && w_strb_q[2:0] == 3'b111) begin
            bus.cpu_addr  <= w_data_q[15:8];
            bus.cpu_wdata <= w_data_q[7:0];
            bus.cpu_wr    <= w_data_q[`SADC_H_CMD_WR_BIT];
            bus.cpu_rd    <= !w_data_q[`SADC_H_CMD_WR_BIT];
            rd_pend_q     <= !w_data_q[`SADC_H_CMD_WR_BIT];
         end else if (bus.dev_rvalid) begin
            rd_pend_q <= 1'b0;
            rd_data_q <= bus.dev_rdata;
         end
         if (exec && aw_addr_q == `SADC_H_CTRL_ADDR && w_strb_q[0])
            wait_mode <= w_data_q[0];
      end
   end

   // ----------------------------------------------------------------------
   // read channel: answer one cycle after the address is taken
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `SADC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `SADC_RESP_OKAY;
         case (s_axi_araddr)
            `SADC_H_STAT_ADDR: s_axi_rdata <= {21'h0, wait_mode, rd_pend_q, irq_vec4, rd_data_q};
            `SADC_H_CTRL_ADDR: s_axi_rdata <= {31'h0, wait_mode};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `SADC_RESP_SLVERR;
            end
         endcase
      end else if (r_fire || !s_axi_rvalid) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : sadc_host

// ===== sadc_bus_monitor.sv
// concurrent checks on the data-space bus between the two converter ends
`timescale 1ns/1ps
module sadc_bus_monitor (
   input wire logic       sys_clk,
   input wire logic       resetn,
   input wire logic [7:0] cpu_addr,
   input wire logic       cpu_wr,
   input wire logic       cpu_rd,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] dev_rdata,
   input wire logic       dev_rvalid,
   input wire logic       dev_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   logic       ctl_wr;
   logic       start;
   logic       ien_q;
   logic       busy_q;
   logic       off_q;
   logic [9:0] cnt_q;

   // ----------------------------------------------------------------------
   // helper logic: enable copy, cycles since start, conversion state
   // ----------------------------------------------------------------------
   assign ctl_wr = cpu_wr && cpu_addr == 8'hd1;
   assign start  = ctl_wr && cpu_wdata[5] && cpu_wdata[4];

   // interrupt enable as last written
   always_ff @(posedge sys_clk) begin
      if (!resetn) ien_q <= 1'b0;
      else if (ctl_wr) ien_q <= cpu_wdata[7];
   end

   // cycles since the last start, saturating
   always_ff @(posedge sys_clk) begin
      if (!resetn || start) cnt_q <= 10'h000;
      else if (cnt_q != 10'h3ff) cnt_q <= cnt_q + 10'h001;
   end

   // conversion under way with the interrupt visible
   always_ff @(posedge sys_clk) begin
      if (!resetn) busy_q <= 1'b0;
      else if (start) busy_q <= 1'b1;
      else if (!ien_q || (ctl_wr && !cpu_wdata[4]) || (dev_irq && cnt_q > 10'h001)) busy_q <= 1'b0;
   end

   // conversion aborted by power down
   always_ff @(posedge sys_clk) begin
      if (!resetn || start) off_q <= 1'b0;
      else if (ctl_wr && !cpu_wdata[4] && busy_q) off_q <= 1'b1;
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   rd_answer_a: assert property (cpu_rd |=> dev_rvalid)
      else $error("read strobe not answered next cycle");
   rvalid_cause_a: assert property (dev_rvalid |-> $past(cpu_rd))
      else $error("read answer without a read strobe");
   ctrl_read_a: assert property (dev_rvalid && $past(cpu_addr) == 8'hd1 |->
      dev_rdata[5] == 1'b0 && dev_rdata[3:0] == 4'h0 && dev_rdata[7] == ien_q)
      else $error("control read shows wrong fixed bits");
   eoc_clear_a: assert property (start |-> ##2 !dev_irq)
      else $error("start did not clear the completion flag");
   irq_mask_a: assert property (!ien_q && !$past(ien_q) |-> !dev_irq)
      else $error("interrupt raised while masked");
   conv_time_a: assert property ($rose(dev_irq) && busy_q |-> cnt_q inside {[536:572]})
      else $error("conversion time out of range");
   early_irq_a: assert property (busy_q && cnt_q > 10'h001 && cnt_q < 10'd536 |-> !dev_irq)
      else $error("completion came too early");
   abort_idle_a: assert property (off_q |-> !dev_irq)
      else $error("aborted conversion still completed");
   flag_holds_a: assert property (dev_irq && !ctl_wr && !$past(ctl_wr) |=> dev_irq)
      else $error("completion flag dropped without a control write");

   cover property ($rose(dev_irq) && busy_q);
   cover property (start && busy_q);
   cover property (off_q);
endmodule : sadc_bus_monitor

// ===== testbench.sv
// self-checking testbench of the processor and converter ends together
`timescale 1ns/1ps
module testbench;
   import sadc_pkg::*;

   logic        sys_clk, resetn, cmp_in, conv_power, conv_busy, irq_vec4, wait_mode;
   logic [7:0]  ain, dac_code, b;
   logic [3:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, w;
   logic [1:0]  bresp, rresp, r;
   int          bad_count, tests_run;
   logic [7:0]  lvls [5] = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h80};

   sadc_bus_if i_sadc_bus_if ();

   sadc_host i_sadc_host (.sys_clk(sys_clk), .resetn(resetn), .bus(i_sadc_bus_if.host),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq_vec4(irq_vec4), .wait_mode(wait_mode));

   sadc_device i_sadc_device (.sys_clk(sys_clk), .resetn(resetn), .bus(i_sadc_bus_if.device),
      .cmp_in(cmp_in), .dac_code(dac_code), .conv_power(conv_power), .conv_busy(conv_busy));

   sadc_bus_monitor i_sadc_bus_monitor (.sys_clk(sys_clk), .resetn(resetn),
      .cpu_addr(i_sadc_bus_if.cpu_addr), .cpu_wr(i_sadc_bus_if.cpu_wr),
      .cpu_rd(i_sadc_bus_if.cpu_rd), .cpu_wdata(i_sadc_bus_if.cpu_wdata),
      .dev_rdata(i_sadc_bus_if.dev_rdata), .dev_rvalid(i_sadc_bus_if.dev_rvalid),
      .dev_irq(i_sadc_bus_if.dev_irq));

   // ----------------------------------------------------------------------
   // clock, comparator model and watchdog
   // ----------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // comparator: high while the analog level is at or above the trial code
   always @(posedge sys_clk) cmp_in <= (ain >= dac_code);

   // cuts a hang short
   initial begin
      #200000;
      bad_count++;
      test_done();
   end

   // ----------------------------------------------------------------------
   // access and compare tasks
   // ----------------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge sys_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid || awvalid || wvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] rs;
      axi_wr(4'h0, {15'h0000, 1'b1, a, d}, rs);
   endtask : dev_wr

   task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
      logic [31:0] v;
      logic [1:0]  rs;
      axi_wr(4'h0, {16'h0000, a, 8'h00}, rs);
      // poll the status word until the read is no longer pending
      do begin
         axi_rd(4'h4, v, rs);
      end while (v[9] !== 1'b0);
      d = v[7:0];
   endtask : dev_rd

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq_vec4 !== 1'b1 && n < 800) begin
         @(posedge sys_clk);
         n++;
      end
   endtask : wait_irq

   // powered start of one conversion on a given level
   task automatic conv(input logic [7:0] v);
      logic [7:0] d;
      @(posedge sys_clk);
      ain <= v;
      dev_wr(8'hd1, 8'h90);
      dev_wr(8'hd1, 8'hb0);
      dev_rd(8'hd1, d);
      chk("ctrl after start", 8'h90, d);
      chk("conv_power", 1'b1, conv_power);
      wait_irq();
      chk("irq_vec4", 1'b1, irq_vec4);
      dev_rd(8'hd1, d);
      chk("ctrl at end", 8'hd0, d);
      dev_rd(8'hd0, d);
      chk("result", v, d);
   endtask : conv

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, ain} = '0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      dev_rd(8'hd1, b);
      chk("ctrl reset", 8'h40, b);
      dev_rd(8'hd0, b);
      chk("result reset", 8'h00, b);
      dev_rd(8'h55, b);
      chk("unmapped byte", 8'h00, b);
      axi_rd(4'hc, w, r);
      chk("axi unmapped", 2'b10, r);
      axi_wr(4'hc, 32'h0, r);
      chk("axi unmapped wr", 2'b10, r);
      axi_wr(4'h8, 32'h1, r);
      chk("ctrl bresp", 2'b00, r);
      axi_rd(4'h8, w, r);
      chk("wait flag", 1'b1, w[0]);
      chk("wait_mode", 1'b1, wait_mode);
      foreach (lvls[i]) conv(lvls[i]);
      // restart while running
      ain <= 8'h11;
      dev_wr(8'hd1, 8'hb0);
      repeat (300) @(posedge sys_clk);
      chk("irq mid conversion", 1'b0, irq_vec4);
      ain <= 8'hc3;
      dev_wr(8'hd1, 8'hb0);
      repeat (300) @(posedge sys_clk);
      chk("irq after restart", 1'b0, irq_vec4);
      wait_irq();
      dev_rd(8'hd0, b);
      chk("restart result", 8'hc3, b);
      // read-only places and one conversion per start
      ain <= 8'h3c;
      dev_wr(8'hd0, 8'h33);
      dev_wr(8'hd1, 8'h90);
      dev_rd(8'hd1, b);
      chk("flag kept", 8'hd0, b);
      repeat (700) @(posedge sys_clk);
      dev_rd(8'hd0, b);
      chk("result kept", 8'hc3, b);
      // masked completion stays pending
      dev_wr(8'hd1, 8'h30);
      repeat (700) @(posedge sys_clk);
      chk("masked irq", 1'b0, irq_vec4);
      dev_rd(8'hd1, b);
      chk("masked ctrl", 8'h50, b);
      dev_wr(8'hd1, 8'h90);
      repeat (5) @(posedge sys_clk);
      chk("pending irq", 1'b1, irq_vec4);
      // power down aborts a running conversion
      dev_wr(8'hd1, 8'hb0);
      repeat (100) @(posedge sys_clk);
      dev_wr(8'hd1, 8'h80);
      repeat (3) @(posedge sys_clk);
      chk("power off", 2'b00, {conv_power, conv_busy});
      repeat (700) @(posedge sys_clk);
      dev_rd(8'hd1, b);
      chk("aborted ctrl", 8'h80, b);
      // reset in mid conversion
      dev_wr(8'hd1, 8'h90);
      dev_wr(8'hd1, 8'hb0);
      repeat (100) @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk("busy after reset", 1'b0, conv_busy);
      dev_rd(8'hd1, b);
      chk("ctrl after reset", 8'h40, b);
      chk("irq after reset", 1'b0, irq_vec4);
      test_done();
   end
endmodule : testbench
